// ==== src/home_timing_source_select.sv ====
// module: routes one timing source to mechanical home seeking
`timescale 1ns/1ps
module home_timing_source_select #(
   parameter logic NV_VALID_DEFAULT = 1'h0  // nonvolatile store holds no value yet
) (
   input  wire logic                          mclk,
   input  wire logic                          reset_n,
   input  wire home_timing_pkg::timing_pins_t pins_in,
   input  wire home_timing_pkg::tsrc_cmd_t    cmd_in,
   input  wire logic [1:0]                    encoder_source_select,
   input  wire logic                          home_seek_pos_cmd,
   input  wire logic                          home_seek_neg_cmd,
   input  wire logic                          home_seek_type,
   input  wire logic                          alarm_clear,
   output      logic                          timing_out_ff,
   output      logic                          alarm_ff,
   output      logic                          timing_source_select_ff,
   output      logic                          timing_source_pending_ff
);
   import home_timing_pkg::*;

   // ----------------------------------------
   // state
   // ----------------------------------------
   // everything that reset_n clears travels in one struct
   sel_state_t state_ff;
   sel_state_t nxt_state;
   // nonvolatile copy: it must outlive reset_n, so it stays out of the reset domain;
   // its declared start values stand for the content of a part fresh from the factory
   logic       nv_valid_ff = NV_VALID_DEFAULT;
   logic       nv_value_ff = TSRC_FACTORY;
   logic       nxt_nv_valid;
   logic       nxt_nv_value;
   // decoded terms of the current cycle
   logic       shared_path;
   logic       seek_cmd;
   logic       no_source;

   // ----------------------------------------
   // next-state logic
   // ----------------------------------------
   // one process works out the whole next state, nonvolatile copy included
   always_comb begin
      nxt_state    = state_ff;
      nxt_nv_valid = nv_valid_ff;
      nxt_nv_value = nv_value_ff;

      // pins come from another timing world: two flops, and only the second is read
      nxt_state.meta   = pins_in;
      nxt_state.pins   = state_ff.meta;
      nxt_state.loaded = 1'h1;

      // first edge after release: take the saved value, as a fresh power-up would
      if (!state_ff.loaded) begin
         nxt_state.active  = nv_valid_ff ? nv_value_ff : TSRC_FACTORY;
         nxt_state.pending = nv_valid_ff ? nv_value_ff : TSRC_FACTORY;
      end
      // writes from a sequence are dropped; a direct write moves pending, never active
      if (cmd_in.wr && !cmd_in.in_sequence) begin
         nxt_state.pending = cmd_in.wdata;
      end
      // save copies pending, a write of the same cycle included, into the store
      if (cmd_in.save) begin
         nxt_nv_valid = 1'h1;
         nxt_nv_value = nxt_state.pending;
      end

      // driver timing and encoder z ride the same shared input; encoder source picks one
      if (encoder_source_select == ENC_DRIVER) begin
         shared_path = state_ff.pins.driver_timing_diff;
      end else if (encoder_source_select == ENC_EXTERNAL) begin
         shared_path = state_ff.pins.ext_encoder_z;
      end else begin
         // none and the unused code 3 both leave the path quiet
         shared_path = TIMING_IDLE;
      end
      // the setting in effect picks the single-ended input or the shared path
      if (state_ff.active == TSRC_SINGLE) begin
         nxt_state.timing = state_ff.pins.timing_single_ended;
      end else begin
         nxt_state.timing = shared_path;
      end

      // alarm is sticky; a raise beats a clear of the same cycle, so no timing seek with no source goes unreported
      seek_cmd  = (home_seek_pos_cmd || home_seek_neg_cmd) && home_seek_type;
      no_source = (state_ff.active == TSRC_SHARED) && (encoder_source_select == ENC_NONE);
      if (alarm_clear) begin
         nxt_state.alarm = 1'h0;
      end
      if (seek_cmd && no_source) begin
         nxt_state.alarm = 1'h1;
      end

      // readback follows the pending value, not the one in effect
      nxt_state.rd_value = nxt_state.pending;
   end

   // ----------------------------------------
   // registers
   // ----------------------------------------
   // async reset clears all but the nonvolatile copy
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         state_ff <= STATE_RESET;
      end else begin
         state_ff <= nxt_state;
      end
   end

   // no reset here on purpose: a reset must not forget what was saved
   always_ff @(posedge mclk) begin
      nv_valid_ff <= nxt_nv_valid;
      nv_value_ff <= nxt_nv_value;
   end

   // ----------------------------------------
   // outputs
   // ----------------------------------------
   // every output is a flop of the state struct
   assign timing_out_ff            = state_ff.timing;
   assign alarm_ff                 = state_ff.alarm;
   assign timing_source_select_ff  = state_ff.active;
   assign timing_source_pending_ff = state_ff.rd_value;

   // ----------------------------------------
   // checks
   // ----------------------------------------
   // selector parked on the shared path with nothing behind it
   sequence s_no_source;
      state_ff.active == TSRC_SHARED && encoder_source_select == ENC_NONE;
   endsequence

   // a home seek whose type waits for the timing signal
   sequence s_timing_seek;
      (home_seek_pos_cmd || home_seek_neg_cmd) && home_seek_type;
   endsequence

   // setting write from immediate mode, after the load edge
   sequence s_direct_write;
      state_ff.loaded && cmd_in.wr && !cmd_in.in_sequence;
   endsequence

   // setting write attempted from inside a stored sequence
   sequence s_sequence_write;
      state_ff.loaded && cmd_in.wr && cmd_in.in_sequence;
   endsequence

   // the load edge, split by whether anything was ever saved
   sequence s_load_saved;
      !state_ff.loaded && nv_valid_ff;
   endsequence

   sequence s_load_factory;
      !state_ff.loaded && !nv_valid_ff;
   endsequence

   // a seek with no source raises the alarm, even beside a clear
   a_alarm_on_seek: assert property (@(posedge mclk) disable iff (!reset_n)
      s_no_source ##0 s_timing_seek |=> alarm_ff)
      else $error("alarm not raised on seek with no source");

   // sticky: only alarm_clear takes it down
   a_alarm_held: assert property (@(posedge mclk) disable iff (!reset_n)
      (alarm_ff && !alarm_clear) |=> alarm_ff)
      else $error("alarm dropped without a clear");

   // nothing but a timing seek with no source raises it
   a_alarm_cause: assert property (@(posedge mclk) disable iff (!reset_n)
      (!alarm_ff && !((home_seek_pos_cmd || home_seek_neg_cmd) && home_seek_type
         && state_ff.active == TSRC_SHARED && encoder_source_select == ENC_NONE)) |=> !alarm_ff)
      else $error("alarm raised without a cause");

   // a clear with no seek beside it always lands
   a_alarm_cleared: assert property (@(posedge mclk) disable iff (!reset_n)
      (alarm_clear && !home_seek_pos_cmd && !home_seek_neg_cmd) |=> !alarm_ff)
      else $error("alarm not cleared");

   // single-ended input reaches the output one flop after the synchroniser
   a_single_route: assert property (@(posedge mclk) disable iff (!reset_n)
      (state_ff.loaded && state_ff.active == TSRC_SINGLE)
      |=> timing_out_ff == $past(state_ff.pins.timing_single_ended))
      else $error("single-ended input not routed");

   // shared path with the driver chosen
   a_driver_route: assert property (@(posedge mclk) disable iff (!reset_n)
      (state_ff.active == TSRC_SHARED && encoder_source_select == ENC_DRIVER)
      |=> timing_out_ff == $past(state_ff.pins.driver_timing_diff))
      else $error("driver timing not routed");

   // shared path with the external encoder chosen
   a_encz_route: assert property (@(posedge mclk) disable iff (!reset_n)
      (state_ff.active == TSRC_SHARED && encoder_source_select == ENC_EXTERNAL)
      |=> timing_out_ff == $past(state_ff.pins.ext_encoder_z))
      else $error("encoder z not routed");

   // no source leaves the home logic an idle level
   a_none_quiet: assert property (@(posedge mclk) disable iff (!reset_n)
      s_no_source |=> timing_out_ff == TIMING_IDLE)
      else $error("timing active with no source");

   // the setting in effect moves only at the load edge
   a_active_frozen: assert property (@(posedge mclk) disable iff (!reset_n)
      state_ff.loaded |=> $stable(state_ff.active))
      else $error("active setting changed without reset");

   // a save stores the pending value for the next reset
   a_save_stored: assert property (@(posedge mclk) disable iff (!reset_n)
      (state_ff.loaded && cmd_in.save && !cmd_in.wr)
      |=> nv_valid_ff && nv_value_ff == $past(state_ff.pending))
      else $error("save did not store the setting");

   // writes from a sequence leave the setting alone
   a_seq_readonly: assert property (@(posedge mclk) disable iff (!reset_n)
      s_sequence_write |=> $stable(state_ff.pending))
      else $error("sequence wrote the setting");

   // a direct write shows up on the readback one cycle later
   a_direct_write: assert property (@(posedge mclk) disable iff (!reset_n)
      s_direct_write |=> timing_source_pending_ff == $past(cmd_in.wdata))
      else $error("direct write not taken");

   // never saved: the factory value comes up
   a_factory_load: assert property (@(posedge mclk) disable iff (!reset_n)
      s_load_factory |=> timing_source_select_ff == TSRC_FACTORY)
      else $error("factory default not loaded");

   // saved before: the stored value comes up
   a_saved_load: assert property (@(posedge mclk) disable iff (!reset_n)
      s_load_saved |=> timing_source_select_ff == $past(nv_value_ff))
      else $error("saved setting not loaded");
endmodule

// ==== src/home_timing_pkg.sv ====
// package: encodings, struct types and constants for the home timing source selector
package home_timing_pkg;
   // ----------------------------------------
   // setting encodings
   // ----------------------------------------
   localparam logic       TSRC_SHARED       = 1'h0;  // driver timing / encoder z path
   localparam logic       TSRC_SINGLE       = 1'h1;  // single-ended timing input
   localparam logic       TSRC_FACTORY      = 1'h1;  // factory default when nothing saved
   localparam logic [1:0] ENC_NONE          = 2'h0;
   localparam logic [1:0] ENC_DRIVER        = 2'h1;
   localparam logic [1:0] ENC_EXTERNAL      = 2'h2;

   // ----------------------------------------
   // carriers
   // ----------------------------------------
   typedef struct packed {
      logic driver_timing_diff;
      logic ext_encoder_z;
      logic timing_single_ended;
   } timing_pins_t;

   typedef struct packed {
      logic       wr;          // write strobe for timing_source_select
      logic       wdata;
      logic       in_sequence; // access comes from a stored sequence
      logic       save;        // save_params_cmd
   } tsrc_cmd_t;

   // state that reset_n clears; the nonvolatile copy lives apart since it must survive reset
   typedef struct packed {
      timing_pins_t meta;      // first synchroniser stage per pin
      timing_pins_t pins;      // second stage, read by logic
      logic         loaded;    // saved setting already taken since release
      logic         pending;   // written, not yet active
      logic         active;    // value in effect since reset
      logic         timing;    // selected timing output
      logic         alarm;     // sticky system alarm
      logic         rd_value;  // readback of pending value
   } sel_state_t;

   // ----------------------------------------
   // reset values
   // ----------------------------------------
   localparam logic         TIMING_IDLE = 1'h0;  // level seen when no source is routed
   localparam timing_pins_t PINS_IDLE   = '0;
   localparam sel_state_t   STATE_RESET = '{
      meta:     PINS_IDLE,
      pins:     PINS_IDLE,
      loaded:   1'h0,
      pending:  TSRC_FACTORY,
      active:   TSRC_FACTORY,
      timing:   TIMING_IDLE,
      alarm:    1'h0,
      rd_value: TSRC_FACTORY
   };
endpackage

// ==== dv/timing_pin_model.sv ====
// partner model: driver timing, encoder z and single-ended timing pins
`timescale 1ns/1ps
module timing_pin_model (
   input  wire logic [2:0]               level,
   output home_timing_pkg::timing_pins_t pins
);
   import home_timing_pkg::*;
   // pins are asynchronous to mclk: land mid-cycle so the synchroniser sees real skew
   initial pins = '0;
   always @(level) begin
      pins <= #37 timing_pins_t'(level);
   end
endmodule

// ==== dv/testbench.sv ====
// testbench: random and corner checks of the home timing source selector
`timescale 1ns/1ps
module testbench;
   import home_timing_pkg::*;
   logic         mclk = 1'b0;
   logic         reset_n = 1'b0;
   logic [2:0]   level = 3'h0;
   tsrc_cmd_t    cmd_in = '0;
   logic [1:0]   encoder_source_select = 2'h0;
   logic         home_seek_pos_cmd = 1'b0;
   logic         home_seek_neg_cmd = 1'b0;
   logic         home_seek_type = 1'b0;
   logic         alarm_clear = 1'b0;
   timing_pins_t pins;
   logic         t_out, alarm, sel, pend;
   logic [3:0]   r;
   int           failures = 0;
   int           checks_done = 0;
   always #50 mclk = ~mclk;
   timing_pin_model pin_u (.level(level), .pins(pins));
   home_timing_source_select dut_u (.mclk(mclk), .reset_n(reset_n), .pins_in(pins), .cmd_in(cmd_in),
      .encoder_source_select(encoder_source_select), .home_seek_pos_cmd(home_seek_pos_cmd),
      .home_seek_neg_cmd(home_seek_neg_cmd), .home_seek_type(home_seek_type), .alarm_clear(alarm_clear),
      .timing_out_ff(t_out), .alarm_ff(alarm), .timing_source_select_ff(sel), .timing_source_pending_ff(pend));
   // ----------------------------------------
   // helpers: inputs change on the falling edge only
   // ----------------------------------------
   task automatic cyc(input int n);
      repeat (n) @(negedge mclk);
   endtask
   task automatic chk(input logic got, input logic exp);
      checks_done++;
      if (got !== exp) begin
         failures++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   function automatic logic exp_timing(input logic s, input logic [1:0] e, input logic [2:0] p);
      if (s == TSRC_SINGLE) return p[0];
      if (e == ENC_DRIVER) return p[2];
      if (e == ENC_EXTERNAL) return p[1];
      return 1'b0;
   endfunction
   task automatic cmd(input logic wr, input logic wd, input logic sq, input logic sv);
      cmd_in = '{wr, wd, sq, sv};
      cyc(1);
      cmd_in = '0;
      cyc(1);
   endtask
   task automatic rst;
      reset_n = 1'b0;
      cyc(2);
      reset_n = 1'b1;
      cyc(2);
   endtask
   // every encoder value, corner pin patterns first, then random; 5 cycles covers sync latency
   task automatic route(input logic s);
      for (int e = 0; e < 4; e++) begin
         for (int k = 0; k < 6; k++) begin
            encoder_source_select = 2'(e);
            level = (k == 0) ? 3'h6 : (k == 1) ? 3'h1 : 3'($urandom);
            cyc(5);
            chk(t_out, exp_timing(s, encoder_source_select, level));
         end
      end
   endtask
   task automatic seek(input logic neg, input logic typ, input logic [1:0] e, input logic exp);
      encoder_source_select = e;
      home_seek_type = typ;
      home_seek_pos_cmd = ~neg;
      home_seek_neg_cmd = neg;
      cyc(1);
      home_seek_pos_cmd = 1'b0;
      home_seek_neg_cmd = 1'b0;
      chk(alarm, exp);
      alarm_clear = 1'b1;
      cyc(1);
      alarm_clear = 1'b0;
      cyc(1);
   endtask
   task automatic complete_run;
      if (failures == 0 && checks_done > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   // ----------------------------------------
   // main sequence
   // ----------------------------------------
   initial begin
      void'($urandom(32'h8aeee774));
      cyc(16);
      reset_n = 1'b1;
      cyc(2);
      chk(sel, TSRC_FACTORY);
      route(TSRC_SINGLE);
      seek(1'b0, 1'b1, ENC_NONE, 1'b0);
      cmd(1'b1, 1'b0, 1'b1, 1'b0);
      chk(pend, 1'b1);
      cmd(1'b1, 1'b0, 1'b0, 1'b0);
      chk(pend, 1'b0);
      chk(sel, 1'b1);
      rst;
      chk(sel, TSRC_FACTORY);
      chk(pend, TSRC_FACTORY);
      cmd(1'b1, 1'b0, 1'b0, 1'b0);
      cmd(1'b0, 1'b0, 1'b0, 1'b1);
      chk(sel, 1'b1);
      rst;
      chk(sel, TSRC_SHARED);
      route(TSRC_SHARED);
      seek(1'b0, 1'b1, ENC_NONE, 1'b1);
      seek(1'b1, 1'b1, ENC_NONE, 1'b1);
      seek(1'b0, 1'b0, ENC_NONE, 1'b0);
      seek(1'b1, 1'b1, ENC_DRIVER, 1'b0);
      seek(1'b0, 1'b1, ENC_EXTERNAL, 1'b0);
      seek(1'b0, 1'b1, 2'h3, 1'b0);
      // clear in the same cycle as a raise must lose
      alarm_clear = 1'b1;
      seek(1'b1, 1'b1, ENC_NONE, 1'b1);
      repeat (12) begin
         r = 4'($urandom);
         seek(r[0], r[1], r[3:2], r[1] && (r[3:2] == ENC_NONE));
      end
      complete_run;
   end
   // watchdog: the sequence needs well under 1000 cycles
   initial begin
      #200000;
      failures++;
      complete_run;
   end
endmodule
